// *** src/rtc_i2c_pkg.sv ***
package rtc_i2c_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCL_HZ = 100_000;
	// Four quarters per serial clock period
	localparam int QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
	localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYCLES - 1);
	// Idle time seen on the bus before a new start may be issued
	localparam int BUS_FREE_NS = 4700;
	localparam int BUS_FREE_CYCLES = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] BUS_FREE_COUNT = 8'(BUS_FREE_CYCLES);
	localparam logic [6:0] TARGET_ADDR = 7'h51;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam int REG_BITS = 5;
	localparam int LEN_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [1:0] Q_FIRST = 2'h0;
	localparam logic [1:0] Q_SECOND = 2'h1;
	localparam logic [1:0] Q_THIRD = 2'h2;
	localparam logic [1:0] Q_FOURTH = 2'h3;
endpackage : rtc_i2c_pkg

// *** src/line_sync.sv ***
`timescale 1ns/1ps
module line_sync (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic line_in,
	output logic line_sync_out
);
	logic stage1;

	// Reset to the released level so the bus looks idle at start-up
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1 <= 1'b1;
			line_sync_out <= 1'b1;
		end else begin
			stage1 <= line_in;
			line_sync_out <= stage1;
		end
	end
endmodule : line_sync

// *** src/rtc_i2c_host.sv ***
`timescale 1ns/1ps
module rtc_i2c_host
	import rtc_i2c_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [REG_BITS-1:0] cmd_reg,
	input wire logic [LEN_BITS-1:0] cmd_len,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic ack_err,
	output logic busy,
	output logic bus_busy,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	typedef enum {ST_IDLE, ST_WAIT_FREE, ST_START, ST_BIT, ST_STOP} state_type;
	typedef enum {K_ADDR_W, K_REG, K_WDATA, K_ADDR_R, K_RDATA} kind_type;

	state_type state;
	kind_type kind;
	logic scl_s;
	logic sda_s;
	logic sda_d;
	logic scl_low;
	logic sda_low;
	logic [7:0] qcnt;
	logic [1:0] qph;
	logic tick;
	logic stalled;
	logic active;
	logic [7:0] free_cnt;
	logic [7:0] shreg;
	logic [3:0] bit_idx;
	logic [LEN_BITS-1:0] remaining;
	logic is_read;
	logic [REG_BITS-1:0] reg_sel;
	logic got_ack;
	logic start_seen;
	logic stop_seen;
	logic queued_sda_low;

	line_sync scl_sync (
		.core_clk(core_clk),
		.rst(rst),
		.line_in(scl_i),
		.line_sync_out(scl_s)
	);

	line_sync sda_sync (
		.core_clk(core_clk),
		.rst(rst),
		.line_in(sda_i),
		.line_sync_out(sda_s)
	);

	// Open drain: only ever pull low, release means high
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_low;
	assign sda_oe = sda_low;
	assign cmd_ready = (state == ST_IDLE);
	assign busy = (state != ST_IDLE);

	assign active = (state == ST_START) || (state == ST_BIT) || (state == ST_STOP);
	// A target may hold the clock low; wait for it before timing the high phase
	assign stalled = !scl_low && !scl_s;
	assign tick = active && !stalled && (qcnt == QUARTER_LAST);

	always_ff @(posedge core_clk) begin
		if (rst || !active) begin
			qcnt <= 8'h00;
		end else if (!stalled) begin
			qcnt <= (qcnt == QUARTER_LAST) ? 8'h00 : qcnt + 8'h01;
		end
	end

	// Watch the bus for anyone's start and stop conditions
	assign start_seen = scl_s && sda_d && !sda_s;
	assign stop_seen = scl_s && !sda_d && sda_s;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sda_d <= 1'b1;
			bus_busy <= 1'b0;
			free_cnt <= 8'h00;
		end else begin
			sda_d <= sda_s;
			if (start_seen) begin
				bus_busy <= 1'b1;
			end else if (stop_seen) begin
				bus_busy <= 1'b0;
			end
			if (!(scl_s && sda_s) || bus_busy) begin
				free_cnt <= 8'h00;
			end else if (free_cnt != BUS_FREE_COUNT) begin
				free_cnt <= free_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			kind <= K_ADDR_W;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			qph <= Q_FIRST;
			bit_idx <= 4'h0;
			shreg <= 8'h00;
			remaining <= '0;
			is_read <= 1'b0;
			reg_sel <= '0;
			got_ack <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			wr_take <= 1'b0;
			done <= 1'b0;
			ack_err <= 1'b0;
			queued_sda_low <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			wr_take <= 1'b0;
			done <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cmd_valid) begin
						is_read <= cmd_read;
						reg_sel <= cmd_reg;
						// A read of zero bytes still fetches one
						remaining <= (cmd_read && cmd_len == '0) ? LEN_BITS'(1) : cmd_len;
						ack_err <= 1'b0;
						state <= ST_WAIT_FREE;
					end
				end
				ST_WAIT_FREE: begin
					if (free_cnt == BUS_FREE_COUNT) begin
						state <= ST_START;
						kind <= K_ADDR_W;
						qph <= Q_FIRST;
					end
				end
				ST_START: begin
					if (tick) begin
						qph <= qph + 2'h1;
						case (qph)
							Q_FIRST: sda_low <= 1'b0;
							Q_SECOND: scl_low <= 1'b0;
							Q_THIRD: sda_low <= 1'b1;
							default: begin
								scl_low <= 1'b1;
								// Address byte always follows the start
								shreg <= {TARGET_ADDR, (kind == K_ADDR_R) ? DIR_READ : DIR_WRITE};
								queued_sda_low <= !TARGET_ADDR[6];
								bit_idx <= 4'h0;
								state <= ST_BIT;
							end
						endcase
					end
				end
				ST_BIT: begin
					// Data moves mid low phase; on the clock edge it reads as start or stop
					if (qph == Q_FIRST && qcnt == (QUARTER_LAST >> 1)) begin
						sda_low <= queued_sda_low;
					end
					if (tick) begin
						qph <= qph + 2'h1;
						case (qph)
							Q_FIRST: scl_low <= 1'b0;
							Q_SECOND: ;
							Q_THIRD: begin
								if (bit_idx != ACK_SLOT) begin
									shreg <= {shreg[6:0], sda_s};
								end else begin
									got_ack <= !sda_s;
								end
							end
							default: begin
								scl_low <= 1'b1;
								if (bit_idx != ACK_SLOT) begin
									bit_idx <= bit_idx + 4'h1;
									if (bit_idx == LAST_DATA_BIT) begin
										// Acknowledge read bytes except the last one
										queued_sda_low <= (kind == K_RDATA) && (remaining != LEN_BITS'(1));
									end else begin
										queued_sda_low <= (kind != K_RDATA) && !shreg[7];
									end
								end else if (kind != K_RDATA && !got_ack) begin
									// Refusal: the target did not answer, close with stop
									ack_err <= 1'b1;
									sda_low <= 1'b0;
									state <= ST_STOP;
								end else begin
									bit_idx <= 4'h0;
									case (kind)
										K_ADDR_W: begin
											kind <= K_REG;
											shreg <= {3'h0, reg_sel};
											queued_sda_low <= 1'b1;
										end
										K_ADDR_R: begin
											kind <= K_RDATA;
											queued_sda_low <= 1'b0;
										end
										K_RDATA: begin
											rd_data <= shreg;
											rd_valid <= 1'b1;
											remaining <= remaining - LEN_BITS'(1);
											queued_sda_low <= 1'b0;
											if (remaining == LEN_BITS'(1)) begin
												state <= ST_STOP;
											end
										end
										default: begin
											if (kind == K_REG && is_read) begin
												// Pointer set; restart closes the write
												kind <= K_ADDR_R;
												sda_low <= 1'b0;
												state <= ST_START;
											end else if (remaining == '0) begin
												sda_low <= 1'b0;
												state <= ST_STOP;
											end else begin
												kind <= K_WDATA;
												shreg <= wr_data;
												queued_sda_low <= !wr_data[7];
												wr_take <= 1'b1;
												remaining <= remaining - LEN_BITS'(1);
											end
										end
									endcase
								end
							end
						endcase
					end
				end
				ST_STOP: begin
					if (tick) begin
						qph <= qph + 2'h1;
						case (qph)
							Q_FIRST: sda_low <= 1'b1;
							Q_SECOND: scl_low <= 1'b0;
							Q_THIRD: sda_low <= 1'b0;
							default: begin
								done <= 1'b1;
								state <= ST_IDLE;
							end
						endcase
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule : rtc_i2c_host

// *** sim/rtc_i2c_host_asserts.sv ***
`timescale 1ns/1ps
module rtc_i2c_host_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic rd_valid,
	input wire logic busy,
	input wire logic bus_busy,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_oe,
	input wire logic sda_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] free_cnt;
	logic [7:0] high_cnt;
	// Saturating, so a long idle never wraps to a small count
	always_ff @(posedge core_clk)
		free_cnt <= (rst || !scl_i || !sda_i || bus_busy) ? 8'h00 : free_cnt + 8'(free_cnt != 8'hff);
	always_ff @(posedge core_clk)
		high_cnt <= (rst || scl_oe) ? 8'h00 : high_cnt + 8'(high_cnt != 8'hff);
	AST_IDLE: assert property (!busy |-> !scl_oe && !sda_oe)
		else $error("line held while idle");
	AST_FREE: assert property ($rose(sda_oe) && !bus_busy |-> free_cnt >= 8'h5a)
		else $error("start without bus free time");
	// A repeated start holds the clock high for two quarters, the shortest high phase
	AST_HIGH: assert property ($rose(scl_oe) && busy |-> high_cnt >= 8'h64)
		else $error("clock high phase too short");
	AST_START: assert property ($rose(sda_oe) && scl_i |-> ##[1:6] bus_busy)
		else $error("start not seen");
	AST_STOP: assert property ($fell(sda_oe) && scl_i |-> ##[1:6] !bus_busy)
		else $error("stop not seen");
	AST_TAKE: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready)
		else $error("command not taken");
	AST_DONE: assert property (done |-> (!scl_oe && !sda_oe) ##1 !done)
		else $error("done before bus released");
	AST_BYTE: assert property (rd_valid |=> !rd_valid)
		else $error("read pulse too long");
	AST_LAST: assert property (rd_valid && !sda_oe |-> ##[1:300] done)
		else $error("no stop after unacknowledged read byte");
endmodule : rtc_i2c_host_asserts
bind rtc_i2c_host rtc_i2c_host_asserts chk_u (.*);

// *** sim/rtc_model.sv ***
`timescale 1ns/1ps
module rtc_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic deaf,
	input wire logic slow,
	output logic scl_pull,
	output logic sda_pull
);
	logic [7:0] mem [32];
	logic [7:0] sh;
	logic [7:0] tx;
	logic [4:0] ptr;
	logic act = 1'h0;
	logic rd = 1'h0;
	int bits = 0;
	int nbyte = 0;
	initial begin
		scl_pull = 1'h0;
		sda_pull = 1'h0;
	end
	always @(negedge sda) if (scl) begin
		act = 1'h1;
		bits = 0;
		nbyte = 0;
		rd = 1'h0;
	end
	always @(posedge sda) if (scl) act = 1'h0;
	always @(posedge scl) if (act) begin
		if (bits < 8) sh = {sh[6:0], sda};
		else if (rd && sda) act = 1'h0;
		bits++;
	end
	always @(negedge scl) if (act) begin
		if (bits == 9) begin
			bits = 0;
			sda_pull = 1'h0;
			if (rd) begin
				tx = mem[ptr];
				ptr++;
			end
		end
		if (bits == 8) begin
			if (rd && nbyte > 0) sda_pull = 1'h0;
			else if (nbyte == 0 && (sh[7:1] != 7'h51 || deaf)) act = 1'h0;
			else begin
				sda_pull = 1'h1;
				if (nbyte == 0) rd = sh[0];
				else if (nbyte == 1) ptr = sh[4:0];
				else begin
					mem[ptr] = sh;
					ptr++;
				end
			end
			nbyte++;
			// Stretch past a whole high phase, so a host that ignores it loses a bit
			if (slow) begin
				scl_pull = 1'h1;
				#10000 scl_pull = 1'h0;
			end
		end else if (rd && nbyte > 0) sda_pull = !tx[7 - bits];
	end
endmodule : rtc_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic cmd_valid = 1'h0;
	logic cmd_read = 1'h0;
	logic deaf = 1'h0;
	logic slow = 1'h0;
	logic [4:0] cmd_reg = 5'h00;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic cmd_ready, wr_take, rd_valid, done, ack_err, scl_oe, sda_oe, scl_pull, sda_pull;
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	int mismatches = 0;
	int total_checks = 0;
	wire scl_i = !scl_oe && !scl_pull; // Pull-ups on both lines
	wire sda_i = !sda_oe && !sda_pull;
	always #25 core_clk = !core_clk;
	rtc_i2c_host dut_u (.*, .busy(), .bus_busy(), .scl_o(), .sda_o());
	rtc_model mdl_u (.scl(scl_i), .sda(sda_i), .deaf(deaf), .slow(slow), .scl_pull(scl_pull),
		.sda_pull(sda_pull));
	always @(posedge core_clk) begin
		if (rd_valid === 1'h1) rq.push_back(rd_data);
		if (wr_take === 1'h1 && wq.size() > 0) begin
			void'(wq.pop_front());
			if (wq.size() > 0) wr_data <= #1 wq[0];
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task automatic run(input logic rd, input logic [4:0] r, input logic [7:0] n);
		int i;
		rq = {};
		cmd_valid = 1'h1;
		cmd_read = rd;
		cmd_reg = r;
		cmd_len = n;
		// Let the previous done pulse pass before watching for the next one
		@(posedge core_clk);
		#1;
		cmd_valid = 1'h0;
		for (i = 0; i < 40000 && done !== 1'h1; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (i == 40000) begin
			mismatches++;
			summarize();
		end
	endtask : run
	task automatic sc_no_answer();
		deaf = 1'h1;
		wq = '{8'h77};
		wr_data = 8'h77;
		run(1'h0, 5'h01, 8'h01);
		deaf = 1'h0;
		check("nack flag", {7'h00, ack_err}, 8'h01);
		check("byte left", 8'(wq.size()), 8'h01);
	endtask : sc_no_answer
	task automatic sc_write_read();
		logic [7:0] want [3] = '{8'ha5, 8'h5a, 8'hc3};
		wq = '{8'ha5, 8'h5a, 8'hc3};
		wr_data = 8'ha5;
		run(1'h0, 5'h0e, 8'h03);
		check("ack flag", {7'h00, ack_err}, 8'h00);
		foreach (want[i]) check("stored", mdl_u.mem[14 + i], want[i]);
		run(1'h1, 5'h0e, 8'h03);
		foreach (want[i]) check("read", rq[i], want[i]);
		check("read count", 8'(rq.size()), 8'h03);
	endtask : sc_write_read
	task automatic sc_pointer_slow();
		run(1'h0, 5'h0f, 8'h00);
		check("pointer", {3'h0, mdl_u.ptr}, 8'h0f);
		slow = 1'h1;
		run(1'h1, 5'h0f, 8'h02);
		slow = 1'h0;
		check("slow read 0", rq[0], 8'h5a);
		check("slow read 1", rq[1], 8'hc3);
	endtask : sc_pointer_slow
	initial begin
		repeat (12) @(posedge core_clk);
		#1;
		rst = 1'h0;
		sc_no_answer();
		sc_write_read();
		sc_pointer_slow();
		summarize();
	end
endmodule : tb
